//--- rtl/sbac_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

module sbac_arbiter
    import sbac_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [31:0]          wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    // internal requesters, index 1..6 group A, 7..8 group B; index 0 unused
    input  wire logic [8:0]           bus_req_i,
    input  wire logic [8:0]           bus_release_i,
    output logic      [8:0]           bus_grant_o,
    // external master
    input  wire logic                 outside_master_request_i,
    output logic                      outside_master_grant_o,
    output logic                      mem_if_oe_n_o,
    output logic                      refresh_allowed_o,
    // processor writes into the write buffer
    input  wire logic                 cpu_wr_valid_i,
    input  wire logic [31:0]          cpu_wr_addr_i,
    input  wire logic [31:0]          cpu_wr_data_i,
    output logic                      cpu_wr_ready_o,
    output logic                      wbuf_valid_o,
    output logic      [31:0]          wbuf_addr_o,
    output logic      [31:0]          wbuf_data_o,
    input  wire logic                 wbuf_done_i,
    // configuration outputs
    output logic                      stall_on_bit_o,
    output logic                      cache_enable_o,
    output logic                      write_buffer_enable_o,
    output logic      [1:0]           cache_layout_field_o,
    output logic      [9:0]           sram_base_o,
    output logic      [9:0]           special_base_o,
    output logic                      sync_dram_mode_bit_o
);
    import sbac_pkg::*;

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [8:0] sbac_first_one(input logic [8:0] v);
        logic [8:0] r;
        r = 9'h000;
        for (int i = REQ_COUNT - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 9'h000;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction : sbac_first_one

    // ****************************************************************
    // configuration register and wishbone slave
    // ****************************************************************
    logic [31:0]    system_configuration_r;
    logic [31:0]    cfg_nxt;
    logic           in_space;
    logic [15:0]    ofs;
    logic           access;
    sbac_state_type state_r;
    logic           wbuf_full;
    logic           wbuf_empty;
    logic [8:0]     req_all;

    // ****************************************************************
    // register bus timing
    // ****************************************************************
    // one access: request seen on edge one, ack registered there,
    // and the write lands on the edge where the master samples ack,
    // so address, select and data are still held by the master.
    // status at offset 4 is read only; writes there are acked and dropped.
    // relocatable 64k window at programmed base
    assign in_space = wb_adr_i[SPECIAL_BASE_HI:SPECIAL_BASE_LO]
                      == system_configuration_r[SPECIAL_BASE_HI:SPECIAL_BASE_LO]
                      && wb_adr_i[31:26] == 6'h00;
    assign ofs    = wb_adr_i[SPECIAL_SPACE_BITS-1:0];
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;

    always_comb
    begin
        cfg_nxt = system_configuration_r;
        for (int b = 0; b < 4; b++)
        begin
            if (wb_sel_i[b])
            begin
                cfg_nxt[b*8 +: 8] = (wb_dat_i[b*8 +: 8] & CONFIG_WRITE_MASK[b*8 +: 8])
                                  | (system_configuration_r[b*8 +: 8]
                                     & ~CONFIG_WRITE_MASK[b*8 +: 8]);
            end
        end
        // no-cache layout forces cache off
        if (wb_sel_i[0] && cfg_nxt[CACHE_LAYOUT_HI:CACHE_LAYOUT_LO] == CACHE_LAYOUT_NO_CACHE)
        begin
            cfg_nxt[CACHE_ENABLE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            system_configuration_r <= SYSTEM_CONFIGURATION_RST;
        end
        else if (wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && in_space
                 && ofs == SYSTEM_CONFIGURATION_OFS)
        begin
            system_configuration_r <= cfg_nxt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= access && in_space
                        && (ofs == SYSTEM_CONFIGURATION_OFS || ofs == ARB_STATUS_OFS);
            wb_err_o <= access && !(in_space
                        && (ofs == SYSTEM_CONFIGURATION_OFS || ofs == ARB_STATUS_OFS));
            if (access && in_space && ofs == SYSTEM_CONFIGURATION_OFS)
            begin
                wb_dat_o <= system_configuration_r;
            end
            else if (access && in_space && ofs == ARB_STATUS_OFS)
            begin
                wb_dat_o <= {9'h000,
                             wbuf_full,
                             wbuf_empty,
                             state_r == SBAC_BUSY,
                             outside_master_grant_o,
                             req_all[8:0],
                             1'b0,
                             bus_grant_o[8:0]};
            end
            else
            begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    assign stall_on_bit_o        = system_configuration_r[STALL_ON_BIT];
    assign cache_enable_o        = system_configuration_r[CACHE_ENABLE_BIT];
    assign write_buffer_enable_o = system_configuration_r[WRITE_BUF_EN_BIT];
    assign cache_layout_field_o  = system_configuration_r[CACHE_LAYOUT_HI:CACHE_LAYOUT_LO];
    assign sram_base_o           = system_configuration_r[SRAM_BASE_HI:SRAM_BASE_LO];
    assign special_base_o        = system_configuration_r[SPECIAL_BASE_HI:SPECIAL_BASE_LO];
    assign sync_dram_mode_bit_o  = system_configuration_r[SYNC_DRAM_MODE_BIT];

    // ****************************************************************
    // arbiter
    // ****************************************************************
    logic [8:0] grant_r;
    logic       b_first_r;
    logic       ext_grant_r;
    logic [8:0] pick;
    logic [8:0] pick_a;
    logic [8:0] pick_b;
    logic       release_now;

    // fixed order inside each group, lowest index wins.
    // group precedence flips on every grant, so neither group starves;
    // a group with nothing pending never blocks the other.
    // no preemption: a higher request waits for the release, and
    // the release costs one idle cycle before the next grant.
    // slot 0 is the outside master; its internal request line is unused
    assign req_all = {bus_req_i[8:1], outside_master_request_i};
    assign pick_a  = sbac_first_one({2'b00, req_all[6:0]});
    assign pick_b  = sbac_first_one({req_all[8:7], 7'h00});

    always_comb
    begin
        if (b_first_r && pick_b != 9'h000)
        begin
            pick = pick_b;
        end
        else if (pick_a != 9'h000)
        begin
            pick = pick_a;
        end
        else
        begin
            pick = pick_b;
        end
    end

    // outside master releases by dropping request; others by pulse
    assign release_now = ext_grant_r ? !outside_master_request_i
                                     : |(grant_r & bus_release_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r     <= SBAC_IDLE;
            grant_r     <= 9'h000;
            ext_grant_r <= 1'b0;
            b_first_r   <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                SBAC_IDLE:
                begin
                    if (pick != 9'h000)
                    begin
                        state_r     <= SBAC_BUSY;
                        grant_r     <= pick;
                        ext_grant_r <= pick[0];
                        b_first_r   <= !b_first_r;
                    end
                end
                SBAC_BUSY:
                begin
                    if (release_now)
                    begin
                        state_r     <= SBAC_IDLE;
                        grant_r     <= 9'h000;
                        ext_grant_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    // gated so a dropped request removes the grant in the same cycle
    assign outside_master_grant_o = ext_grant_r && outside_master_request_i;
    assign bus_grant_o            = {grant_r[8:1], 1'b0};
    assign mem_if_oe_n_o          = outside_master_grant_o;
    assign refresh_allowed_o      = !ext_grant_r;

    // ****************************************************************
    // write buffer, write-through
    // ****************************************************************
    // address and data kept side by side in one entry.
    // entries are not reset: valid comes only from the count, so
    // stale contents are never presented as a pending write.
    // the head is read combinationally; the consumer pops with done.
    logic [63:0] wbuf_mem [WBUF_DEPTH];
    logic [1:0]  wr_ptr_r;
    logic [1:0]  rd_ptr_r;
    logic [2:0]  count_r;
    logic        push;
    logic        pop;

    assign wbuf_full      = count_r == 3'(WBUF_DEPTH);
    assign wbuf_empty     = count_r == 3'h0;
    // disabled buffer still passes one write through at a time
    assign cpu_wr_ready_o = write_buffer_enable_o ? !wbuf_full : wbuf_empty;
    assign push           = cpu_wr_valid_i && cpu_wr_ready_o;
    assign pop            = wbuf_valid_o && wbuf_done_i;
    assign wbuf_valid_o   = !wbuf_empty;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            wbuf_mem[wr_ptr_r] <= {cpu_wr_addr_i, cpu_wr_data_i};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_r <= 2'h0;
            rd_ptr_r <= 2'h0;
            count_r  <= 3'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_r <= wr_ptr_r + 2'h1;
            end
            if (pop)
            begin
                rd_ptr_r <= rd_ptr_r + 2'h1;
            end
            if (push && !pop)
            begin
                count_r <= count_r + 3'h1;
            end
            else if (pop && !push)
            begin
                count_r <= count_r - 3'h1;
            end
        end
    end

    assign wbuf_addr_o = wbuf_mem[rd_ptr_r][63:32];
    assign wbuf_data_o = wbuf_mem[rd_ptr_r][31:0];
endmodule : sbac_arbiter

`default_nettype wire

//--- rtl/sbac_pkg.sv
package sbac_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [15:0] SYSTEM_CONFIGURATION_OFS = 16'h0000;
    localparam logic [15:0] ARB_STATUS_OFS           = 16'h0004;
    localparam logic [31:0] SYSTEM_CONFIGURATION_RST = 32'h37ff_ff91;
    localparam int          SPECIAL_SPACE_BITS       = 16;

    // ****************************************************************
    // configuration fields
    // ****************************************************************
    localparam int STALL_ON_BIT        = 0;
    localparam int CACHE_ENABLE_BIT    = 1;
    localparam int WRITE_BUF_EN_BIT    = 2;
    localparam int CACHE_LAYOUT_LO     = 4;
    localparam int CACHE_LAYOUT_HI     = 5;
    localparam int SRAM_BASE_LO        = 6;
    localparam int SRAM_BASE_HI        = 15;
    localparam int SPECIAL_BASE_LO     = 16;
    localparam int SPECIAL_BASE_HI     = 25;
    localparam int SYNC_DRAM_MODE_BIT  = 31;
    localparam logic [1:0]  CACHE_LAYOUT_NO_CACHE = 2'h2;
    localparam logic [31:0] CONFIG_WRITE_MASK     = 32'h83ff_fff7;

    // ****************************************************************
    // requesters, index 0 is highest in its group
    // ****************************************************************
    localparam int GROUP_A_COUNT = 7;
    localparam int GROUP_B_COUNT = 2;
    localparam int REQ_COUNT     = GROUP_A_COUNT + GROUP_B_COUNT;
    localparam int WBUF_DEPTH    = 4;

    typedef enum logic [1:0] {SBAC_IDLE, SBAC_BUSY} sbac_state_type;
endpackage : sbac_pkg

//--- verification/sbac_bus_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sbac_bus_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       load_i,
    input  wire logic [8:0] pend_i,
    input  wire logic [3:0] hold_i,
    input  wire logic       drain_i,
    input  wire logic [8:0] bus_grant_i,
    input  wire logic       outside_grant_i,
    input  wire logic       wbuf_valid_i,
    output logic      [8:0] bus_req_o,
    output logic      [8:0] bus_release_o,
    output logic            outside_req_o,
    output logic            wbuf_done_o
);
    logic [8:0] pend_r;
    logic [3:0] cnt_r;
    logic [8:0] own;
    logic       rel;
    assign own = {bus_grant_i[8:1], outside_grant_i};
    assign rel = |own && cnt_r == hold_i;
    // a single outside master: several would be ranked before slot 0
    // this master drives no memory pins, so select-first order holds
    assign outside_req_o = pend_r[0];
    assign bus_req_o     = {pend_r[8:1], 1'h0};
    always_ff @(posedge clk_i)
    begin
        cnt_r         <= (rst_i || !(|own)) ? 4'h0 : cnt_r + 4'h1;
        pend_r        <= rst_i ? 9'h000 : (pend_r & ~(rel ? own : 9'h000))
                         | (load_i ? pend_i : 9'h000);
        // holder gives the bus back itself, slot 0 by dropping its request
        bus_release_o <= (rst_i || !rel) ? 9'h000 : own & 9'h1fe;
        // pops every other cycle, so the head is seen stalled in between
        wbuf_done_o   <= !rst_i && drain_i && wbuf_valid_i && !wbuf_done_o;
    end
endmodule : sbac_bus_partner
`default_nettype wire

//--- verification/sbac_arbiter_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sbac_arbiter_chk
    import sbac_pkg::*;
(
    input  wire logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o,
    input  wire logic        outside_master_request_i, outside_master_grant_o,
    input  wire logic        mem_if_oe_n_o, refresh_allowed_o, cache_enable_o,
    input  wire logic        sync_dram_mode_bit_o, write_buffer_enable_o,
    input  wire logic [31:0] wb_adr_i, wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [8:0]  bus_grant_o, bus_release_i,
    input  wire logic [9:0]  special_base_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire logic cfg_hit = wb_adr_i == {6'h00, special_base_o, SYSTEM_CONFIGURATION_OFS};
    sequence s_cfg_wr;
        wb_ack_o && wb_we_i && cfg_hit;
    endsequence
    a_one_grant: assert property ($onehot0(bus_grant_o) && !bus_grant_o[0])
        else $error("more than one grant");
    a_grant_held: assert property (|bus_grant_o && !(|(bus_grant_o & bus_release_i))
        |=> bus_grant_o == $past(bus_grant_o)) else $error("grant moved before release");
    a_gap_after: assert property (|(bus_grant_o & bus_release_i)
        |=> bus_grant_o == 9'h000 && !outside_master_grant_o) else $error("no idle gap");
    a_ext_needs_req: assert property (outside_master_grant_o |-> outside_master_request_i)
        else $error("outside grant without request");
    a_ext_alone: assert property (outside_master_grant_o |-> bus_grant_o == 9'h000)
        else $error("two owners at once");
    a_float_mem: assert property (mem_if_oe_n_o == outside_master_grant_o)
        else $error("memory pins not floated with grant");
    a_no_refresh: assert property (outside_master_grant_o [*2]
        |-> !refresh_allowed_o && !bus_grant_o[1]) else $error("refresh while not owner");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o != wb_err_o) else $error("bus answer missing");
    a_err_decode: assert property (wb_err_o |-> !cfg_hit)
        else $error("config address refused");
    a_layout_clr: assert property (s_cfg_wr ##0 wb_sel_i[0]
        && wb_dat_i[5:4] == CACHE_LAYOUT_NO_CACHE |=> !cache_enable_o)
        else $error("cache enable not cleared");
    a_sdram_bit: assert property (s_cfg_wr ##0 wb_sel_i[3]
        |=> sync_dram_mode_bit_o == $past(wb_dat_i[31])) else $error("sdram mode bit");
    a_wbuf_en: assert property (s_cfg_wr ##0 wb_sel_i[0]
        |=> write_buffer_enable_o == $past(wb_dat_i[2])) else $error("write buffer enable");
    a_reset_idle: assert property (disable iff (1'h0) rst_i
        |=> bus_grant_o == 9'h000 && !outside_master_grant_o && special_base_o == 10'h3ff)
        else $error("not idle after reset");
endmodule : sbac_arbiter_chk
bind sbac_arbiter sbac_arbiter_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_ack_o, .wb_err_o, .outside_master_request_i, .outside_master_grant_o, .mem_if_oe_n_o,
    .refresh_allowed_o, .cache_enable_o, .sync_dram_mode_bit_o, .write_buffer_enable_o,
    .wb_adr_i, .wb_dat_i, .wb_sel_i, .bus_grant_o, .bus_release_i, .special_base_o);
`default_nettype wire

//--- verification/sbac_arbiter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sbac_arbiter_tb_top;
    import sbac_pkg::*;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cpu_wr_valid_i, load, drain, e;
    logic [31:0] wb_adr_i, wb_dat_i, cpu_wr_addr_i, cpu_wr_data_i, q;
    logic [3:0]  wb_sel_i, hold;
    logic [8:0]  pend;
    wire logic [31:0] wb_dat_o, wbuf_addr_o, wbuf_data_o;
    wire logic [8:0]  bus_req_i, bus_release_i, bus_grant_o;
    wire logic [9:0]  sram_base_o, special_base_o;
    wire logic [1:0]  cache_layout_field_o;
    wire logic wb_ack_o, wb_err_o, outside_master_request_i, outside_master_grant_o;
    wire logic mem_if_oe_n_o, refresh_allowed_o, cpu_wr_ready_o, wbuf_valid_o, wbuf_done_i;
    wire logic stall_on_bit_o, cache_enable_o, write_buffer_enable_o, sync_dram_mode_bit_o;
    wire logic [26:0] cfg_o = {sync_dram_mode_bit_o, special_base_o, sram_base_o,
        cache_layout_field_o, 1'h0, write_buffer_enable_o, cache_enable_o, stall_on_bit_o};
    int error_cnt, n_compared, cyc_cnt;
    sbac_arbiter i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .bus_req_i, .bus_release_i, .bus_grant_o,
        .outside_master_request_i, .outside_master_grant_o, .mem_if_oe_n_o, .refresh_allowed_o,
        .cpu_wr_valid_i, .cpu_wr_addr_i, .cpu_wr_data_i, .cpu_wr_ready_o, .wbuf_valid_o,
        .wbuf_addr_o, .wbuf_data_o, .wbuf_done_i, .stall_on_bit_o, .cache_enable_o,
        .write_buffer_enable_o, .cache_layout_field_o, .sram_base_o, .special_base_o,
        .sync_dram_mode_bit_o);
    sbac_bus_partner i_far (.clk_i, .rst_i, .load_i(load), .pend_i(pend), .hold_i(hold),
        .drain_i(drain), .bus_grant_i(bus_grant_o), .outside_grant_i(outside_master_grant_o),
        .wbuf_valid_i(wbuf_valid_o), .bus_req_o(bus_req_i), .bus_release_o(bus_release_i),
        .outside_req_o(outside_master_request_i), .wbuf_done_o(wbuf_done_i));
    initial
    begin
        clk_i = 1'h0;
        forever #25 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        // whole run needs well under a thousand cycles
        if (cyc_cnt == 5000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_compared++;
        if (got !== ex)
        begin
            $display("wrong value %s expected %h seen %h", nm, ex, got);
            error_cnt++;
        end
    endtask : chk
    task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (!(wb_ack_o || wb_err_o));
        q = wb_dat_o;
        e = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask : wb
    function automatic logic [31:0] cfg_exp(input logic [31:0] d);
        cfg_exp = (d & CONFIG_WRITE_MASK) | (SYSTEM_CONFIGURATION_RST & ~CONFIG_WRITE_MASK);
        if (d[5:4] == CACHE_LAYOUT_NO_CACHE) cfg_exp[1] = 1'h0;
    endfunction : cfg_exp
    task automatic next_grant(output int g);
        while (!(outside_master_grant_o || |bus_grant_o)) @(posedge clk_i);
        g = outside_master_grant_o ? 0 : $clog2(bus_grant_o);
        @(posedge clk_i);
        if (g == 0) chk("refresh allowed", 0, refresh_allowed_o);
        if (g == 0) chk("memory floated", 1, mem_if_oe_n_o);
        while (outside_master_grant_o || |bus_grant_o) @(posedge clk_i);
    endtask : next_grant
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_cfg();
        logic [31:0] wa[3] = '{32'h03ff_0000, 32'h0000_0000, 32'h03ff_0000};
        logic [31:0] wd[3] = '{32'h8000_0026, 32'h03ff_0017, 32'h03ff_0015};
        logic [31:0] ra[3] = '{32'h0000_0000, 32'h03ff_0000, 32'h03ff_0000};
        logic [31:0] x;
        wb(1'h0, 32'h03ff_0000, 32'h0000_0000);
        chk("reset config", SYSTEM_CONFIGURATION_RST, q);
        chk("reset outputs", 32'h03ff_ff91, {5'h00, cfg_o});
        wb(1'h0, 32'h03ff_0008, 32'h0000_0000);
        chk("unmapped refused", 1, e);
        wb(1'h0, 32'h03ff_0004, 32'h0000_0000);
        chk("status idle", 32'h0020_0000, q);
        for (int k = 0; k < 3; k++)
        begin
            wb(1'h1, wa[k], wd[k]);
            wb(1'h0, ra[k], 32'h0000_0000);
            x = cfg_exp(wd[k]);
            chk("config readback", x, q);
            chk("config outputs", {5'h00, x[31], x[25:0]}, {5'h00, cfg_o});
            if (wa[k] != ra[k]) wb(1'h0, wa[k], 32'h0000_0000);
            if (wa[k] != ra[k]) chk("old window refused", 1, e);
        end
        $display("config test done");
    endtask : t_cfg
    task automatic t_prio();
        int g;
        int ex[7] = '{1, 0, 2, 3, 4, 5, 6};
        {hold, pend, load} <= {4'h4, 9'h07e, 1'h1};
        @(posedge clk_i);
        load <= 1'h0;
        while (!(|bus_grant_o)) @(posedge clk_i);
        {pend, load} <= {9'h001, 1'h1};
        @(posedge clk_i);
        load <= 1'h0;
        for (int k = 0; k < 7; k++)
        begin
            next_grant(g);
            chk("group a order", ex[k], g);
        end
        $display("priority test done");
    endtask : t_prio
    task automatic t_mix();
        int g[6];
        int ea[6] = '{3, 7, 4, 8, 5, 6};
        int eb[6] = '{7, 3, 8, 4, 5, 6};
        {hold, pend, load} <= {4'h1, 9'h1f8, 1'h1};
        @(posedge clk_i);
        load <= 1'h0;
        for (int k = 0; k < 6; k++) next_grant(g[k]);
        for (int k = 0; k < 6; k++) chk("alternation", g[0] < 7 ? ea[k] : eb[k], g[k]);
        $display("group mix test done");
    endtask : t_mix
    task automatic t_wbuf();
        for (int k = 0; k < WBUF_DEPTH; k++)
        begin
            cpu_wr_valid_i <= 1'h1;
            cpu_wr_addr_i  <= 32'h0000_1000 + 32'(k * 4);
            cpu_wr_data_i  <= 32'h5a5a_0000 + 32'(k);
            do @(posedge clk_i); while (!cpu_wr_ready_o);
        end
        cpu_wr_valid_i <= 1'h0;
        @(posedge clk_i);
        chk("ready when full", 0, cpu_wr_ready_o);
        drain <= 1'h1;
        for (int k = 0; k < WBUF_DEPTH; k++)
        begin
            do @(posedge clk_i); while (!wbuf_done_i);
            chk("drained data", 32'h5a5a_0000 + 32'(k), wbuf_data_o);
            chk("drained address", 32'h0000_1000 + 32'(k * 4), wbuf_addr_o);
        end
        drain <= 1'h0;
        @(posedge clk_i);
        chk("buffer empty", 0, wbuf_valid_o);
        $display("write buffer test done");
    endtask : t_wbuf
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial
    begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, cpu_wr_valid_i, load, drain} = 7'h40;
        {wb_adr_i, wb_dat_i, cpu_wr_addr_i, cpu_wr_data_i} = '0;
        {wb_sel_i, hold, pend} = {4'hf, 4'h0, 9'h000};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        chk("grants after reset", 0, {outside_master_grant_o, bus_grant_o});
        t_cfg();
        t_prio();
        t_mix();
        t_wbuf();
        print_verdict();
    end
endmodule : sbac_arbiter_tb_top
`default_nettype wire
